// ### hw/readout_params.svh
`ifndef READOUT_PARAMS_SVH
`define READOUT_PARAMS_SVH

// ==================================================
// Address widths and line geometry
`define START_W 10
`define ROW_W 11
`define COL_W 12
`define LINE_PIXELS 12'h800
`define PIX_W 12

// ==================================================
// Pin index inside the synchroniser vectors
`define PIN_ROW_SYNC 0
`define PIN_ROW_STEP 1
`define PIN_COL_SYNC 2
`define PIN_COL_CLK 3
`define PIN_COUNT 4

// ==================================================
// Sample buffer
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define WORD_W 25

`endif

// ### hw/readout_pkg.sv
package readout_pkg;
  `include "readout_params.svh"

  typedef enum logic [1:0] {
    COL_IDLE = 2'b00,
    COL_ARMED = 2'b01,
    COL_ACTIVE = 2'b11
  } col_state_type;

  typedef struct packed {
    logic [`PIN_COUNT-1:0] sync0;
    logic [`PIN_COUNT-1:0] sync1;
    logic [`PIN_COUNT-1:0] sync_prev;
    logic [`ROW_W-1:0] row_addr;
    logic [`COL_W-1:0] col_addr;
    col_state_type col_state;
    logic dual;
    logic fetch;
    logic pending;
    logic [`WORD_W-1:0] pending_word;
    logic overrun;
    logic line_done;
    logic [`ROW_W-1:0] pix_row;
    logic [`ROW_W-1:0] pix_col_a;
    logic [`ROW_W-1:0] pix_col_b;
    logic [`PIX_W-1:0] out1_level;
    logic [`PIX_W-1:0] out2_level;
  } readout_state_type;
endpackage

// ### hw/sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_type;

  fifo_state_type st_reg;
  fifo_state_type st_next;
  logic [AW:0] fill;

  // ==================================================
  // Flags and next state
  // The extra pointer bit tells full from empty without a separate counter.
  assign fill = st_reg.wr - st_reg.rd;
  assign in_ready = (fill != (AW + 1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = st_reg.mem[st_reg.rd[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid && in_ready) begin
      st_next.mem[st_reg.wr[AW-1:0]] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule // sample_fifo

`default_nettype wire

// ### hw/pixel_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"

module pixel_readout
  import readout_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic row_sync,
  input wire logic row_step,
  input wire logic col_sync,
  input wire logic col_clk,
  input wire logic [`START_W-1:0] row_start,
  input wire logic [`START_W-1:0] col_start,
  input wire logic dual_output,
  output logic [`ROW_W-1:0] pix_row,
  output logic [`ROW_W-1:0] pix_col_a,
  output logic [`ROW_W-1:0] pix_col_b,
  input wire logic [`PIX_W-1:0] pix_data_a,
  input wire logic [`PIX_W-1:0] pix_data_b,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`PIX_W-1:0] out1_level,
  output logic [`PIX_W-1:0] out2_level,
  output logic overrun,
  output logic line_done
);
  readout_state_type st_reg;
  readout_state_type st_next;
  logic [`PIN_COUNT-1:0] rise;
  logic [`PIN_COUNT-1:0] fall;
  logic present;
  logic fifo_in_ready;
  logic [`WORD_W-1:0] fifo_out_data;
  logic [`COL_W-1:0] col_after;
  logic [`ROW_W-1:0] col_here;

  // ==================================================
  // Edge detection
  assign rise = st_reg.sync1 & ~st_reg.sync_prev;
  assign fall = ~st_reg.sync1 & st_reg.sync_prev;
  assign col_here = st_reg.col_addr[`ROW_W-1:0];

  // ==================================================
  // Outputs
  assign pix_row = st_reg.pix_row;
  assign pix_col_a = st_reg.pix_col_a;
  assign pix_col_b = st_reg.pix_col_b;
  assign out1_level = st_reg.out1_level;
  assign out2_level = st_reg.out2_level;
  assign overrun = st_reg.overrun;
  assign line_done = st_reg.line_done;

  // ==================================================
  // Presentation events
  // rising clock edge; the falling edge too once active in single output mode
  always_comb begin
    present = 1'b0;
    unique case (st_reg.col_state)
      COL_IDLE: begin
        present = 1'b0;
      end
      COL_ARMED: begin
        present = rise[`PIN_COL_CLK];
      end
      COL_ACTIVE: begin
        present = rise[`PIN_COL_CLK] || (fall[`PIN_COL_CLK] && !st_reg.dual);
      end
      default: begin
        present = 1'b0;
      end
    endcase
  end

  assign col_after = st_reg.col_addr + (st_reg.dual ? 12'h002 : 12'h001);

  // ==================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sync0 = {col_clk, col_sync, row_step, row_sync};
    st_next.sync1 = st_reg.sync0;
    st_next.sync_prev = st_reg.sync1;
    st_next.fetch = 1'b0;
    st_next.line_done = 1'b0;

    if (st_reg.sync1[`PIN_ROW_SYNC]) begin
      st_next.row_addr = {row_start, 1'b0};
      st_next.col_state = COL_IDLE;
      st_next.overrun = 1'b0;
    end else if (rise[`PIN_ROW_STEP]) begin
      // next line
      // The row address wraps past the last line; the controller bounds the frame.
      st_next.row_addr = st_reg.row_addr + 11'h001;
      st_next.col_state = COL_IDLE;
    end else if (present) begin
      // A new sample while the previous one waits for buffer room is dropped, not queued.
      if (st_reg.pending) begin
        st_next.overrun = 1'b1;
      end else begin
        st_next.fetch = 1'b1;
        st_next.pix_row = st_reg.row_addr;
        st_next.pix_col_a = col_here;
        if (st_reg.dual) begin
          st_next.pix_col_b = col_here + 11'h001;
        end else begin
          st_next.pix_col_b = col_here;
        end
      end
      st_next.col_addr = col_after;
      st_next.col_state = COL_ACTIVE;
      if (col_after >= `LINE_PIXELS) begin
        st_next.col_state = COL_IDLE;
        st_next.line_done = 1'b1;
      end
    end else begin
      unique case (st_reg.col_state)
        COL_IDLE, COL_ARMED: begin
          if (st_reg.sync1[`PIN_COL_SYNC]) begin
            st_next.col_addr = {1'b0, col_start, 1'b0};
            st_next.dual = dual_output;
            st_next.col_state = COL_ARMED;
          end
        end
        COL_ACTIVE: begin
          // Column sync is ignored in mid-line; only a row event ends a line early.
          st_next.col_state = COL_ACTIVE;
        end
        default: begin
          st_next.col_state = COL_IDLE;
        end
      endcase
    end

    // ==================================================
    // Buffer hand-off
    // A word waits here while the buffer is full; the pins keep running regardless.
    if (st_reg.pending && fifo_in_ready) begin
      st_next.pending = 1'b0;
    end
    if (st_reg.fetch) begin
      st_next.pending = 1'b1;
      st_next.pending_word = {st_reg.dual, pix_data_b, pix_data_a};
    end

    // ==================================================
    // Held output levels
    // levels hold until the next sample; out2 holds until the next dual output sample
    if (out_valid && out_ready) begin
      st_next.out1_level = fifo_out_data[`PIX_W-1:0];
      if (fifo_out_data[`WORD_W-1]) begin
        st_next.out2_level = fifo_out_data[2*`PIX_W-1:`PIX_W];
      end
    end
  end

  // ==================================================
  // State register
  // The enable also freezes the synchronisers, so a pin edge that comes and goes while frozen is lost.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ==================================================
  // Sample buffer
  // Sixteen words absorb the gap between the pixel rate and a stalled sink.
  sample_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) sample_fifo_i (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .in_valid(st_reg.pending),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.pending_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out_data)
  );
endmodule // pixel_readout

`default_nettype wire

// ### verification/readout_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"
// ====
// Port checks.
module readout_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic row_sync,
  input wire logic col_clk,
  input wire logic dual_output,
  input wire logic [`ROW_W-1:0] pix_col_a,
  input wire logic [`ROW_W-1:0] pix_col_b,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [`PIX_W-1:0] out1_level,
  input wire logic overrun,
  input wire logic line_done
);
  // Pins cross two flops, so a column move trails its clock phase by three edges.
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_PIX_PHASE: assert property ($changed(pix_col_a) |-> $past(col_clk, 3) != $past(col_clk, 4))
    else $error("column moved without a clock phase");
  AST_SINGLE_PAIR: assert property ($changed(pix_col_a) && !dual_output |-> pix_col_b == pix_col_a)
    else $error("single output pair differs");
  AST_DUAL_PAIR: assert property ($changed(pix_col_a) && dual_output |-> pix_col_b == pix_col_a + 11'h1)
    else $error("dual output pair not adjacent");
  AST_LINE_END: assert property (line_done |-> pix_col_b == 11'h7ff)
    else $error("line ended off the last column");
  AST_DONE_PULSE: assert property (line_done |=> !line_done)
    else $error("line end longer than one cycle");
  AST_LEVEL_HOLD: assert property ($changed(out1_level) |->
    $past(out_valid && out_ready) || $past(out_valid && out_ready, 2))
    else $error("output level moved without a sample");
  AST_SYNC_FREEZE: assert property (row_sync [*5] |=> $stable(pix_col_a))
    else $error("column moved during row sync");
  AST_OVERRUN_CLR: assert property (row_sync [*5] |=> !overrun)
    else $error("overrun kept through row sync");
endmodule // readout_checker
`default_nettype wire

// ### verification/pixel_array_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"
// ====
// Array: each pixel reads back the low six bits of its row and column, so a wrong low address bit shows at the output.
module pixel_array_model (
  input wire logic [`ROW_W-1:0] pix_row,
  input wire logic [`ROW_W-1:0] pix_col_a,
  input wire logic [`ROW_W-1:0] pix_col_b,
  output logic [`PIX_W-1:0] pix_data_a,
  output logic [`PIX_W-1:0] pix_data_b
);
  assign pix_data_a = {pix_row[5:0], pix_col_a[5:0]};
  assign pix_data_b = {pix_row[5:0], pix_col_b[5:0]};
endmodule // pixel_array_model
`default_nettype wire

// ### verification/test_pixel_array_row_column_readout.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_params.svh"
// ====
// Readout bench.
module test_pixel_array_row_column_readout;
  logic mclk = 1'b0, nrst = 1'b0, row_sync = 1'b0, row_step = 1'b0, col_sync = 1'b0, col_clk = 1'b0;
  logic dual_output = 1'b0, out_ready = 1'b1, ce = 1'b1, out_valid, overrun, line_done;
  logic [`START_W-1:0] row_start = 10'h0, col_start = 10'h0;
  logic [`ROW_W-1:0] pix_row, pix_col_a, pix_col_b;
  logic [`PIX_W-1:0] pix_data_a, pix_data_b, out1_level, out2_level;
  int n_errors = 0, samples_checked = 0, done_cnt = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (line_done === 1'b1) done_cnt <= done_cnt + 1;
  pixel_readout pixel_readout_i (.mclk, .nrst, .ce, .row_sync, .row_step, .col_sync, .col_clk, .row_start,
    .col_start, .dual_output, .pix_row, .pix_col_a, .pix_col_b, .pix_data_a, .pix_data_b, .out_valid, .out_ready,
    .out1_level, .out2_level, .overrun, .line_done);
  pixel_array_model pixel_array_model_i (.pix_row, .pix_col_a, .pix_col_b, .pix_data_a, .pix_data_b);
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  // Eight cycles a phase, since the pins are oversampled by mclk.
  // late sampling point
  task automatic ph(logic v);
    col_clk = v;
    cyc(8);
  endtask
  task automatic row_init(logic [9:0] s);
    col_sync = 1'b0;
    row_start = s;
    row_sync = 1'b1;
    cyc(4);
    row_step = 1'b1;
    cyc(4);
    row_step = 1'b0;
    cyc(4);
    row_sync = 1'b0;
    cyc(4);
  endtask
  task automatic step();
    col_sync = 1'b0;
    row_step = 1'b1;
    cyc(8);
    row_step = 1'b0;
    cyc(8);
  endtask
  task automatic line(logic [9:0] c, logic d);
    col_start = c;
    dual_output = d;
    col_sync = 1'b1;
    cyc(8);
  endtask
  // Single output: first column, both phases, then a step closes the window.
  task automatic scen_single();
    row_init(10'h3);
    line(10'h5, 1'b0);
    chk("reset level", 12'h0, out1_level);
    ph(1'b1);
    chk("first pixel", {6'h06, 6'h0a}, out1_level);
    chk("first column", 12'h00a, {1'b0, pix_col_a});
    ph(1'b0);
    chk("low phase", {6'h06, 6'h0b}, out1_level);
    chk("single pair", 12'h00b, {1'b0, pix_col_b});
    step();
  endtask
  // Dual output on the last two columns of the next line.
  task automatic scen_dual();
    line(10'h3ff, 1'b1);
    chk("held level", {6'h06, 6'h0b}, out1_level);
    ph(1'b1);
    chk("next row", 12'h007, {1'b0, pix_row});
    chk("dual a", {6'h07, 6'h3e}, out1_level);
    chk("dual b", {6'h07, 6'h3f}, out2_level);
    chk("dual column b", 12'h7ff, {1'b0, pix_col_b});
    chk("line end", 12'h001, done_cnt[11:0]);
    ph(1'b0);
    step();
  endtask
  // A stalled sink fills the buffer and then loses samples.
  task automatic scen_overrun();
    out_ready = 1'b0;
    line(10'h0, 1'b0);
    repeat (10) begin
      ph(1'b1);
      ph(1'b0);
    end
    chk("overrun", 12'h001, {11'h000, overrun});
    chk("full", 12'h001, {11'h000, out_valid});
    out_ready = 1'b1;
    cyc(40);
    chk("drained", 12'h000, {11'h000, out_valid});
  endtask
  // Row sync, a clock period lost while frozen, then a whole line.
  task automatic scen_full_line();
    row_init(10'h200);
    chk("overrun clear", 12'h000, {11'h000, overrun});
    line(10'h0, 1'b0);
    ce = 1'b0;
    ph(1'b1);
    ph(1'b0);
    ce = 1'b1;
    chk("frozen row", 12'h008, {1'b0, pix_row});
    repeat (1024) begin
      ph(1'b1);
      ph(1'b0);
    end
    chk("sync row", 12'h400, {1'b0, pix_row});
    chk("last pixel", 12'h03f, out1_level);
    chk("line count", 12'h002, done_cnt[11:0]);
  endtask
  initial begin
    cyc(4);
    nrst = 1'b1;
    cyc(2);
    scen_single();
    scen_dual();
    scen_overrun();
    scen_full_line();
    end_sim();
  end
  initial begin
    #2000000;
    n_errors++;
    end_sim();
  end
endmodule // test_pixel_array_row_column_readout
bind pixel_readout readout_checker readout_checker_i (.mclk, .nrst, .row_sync, .col_clk, .dual_output, .pix_col_a,
  .pix_col_b, .out_valid, .out_ready, .out1_level, .overrun, .line_done);
`default_nettype wire
